// *** rtl/fupc_top.v ***
// Flash user program mode controller with Avalon-MM register access
//
// Summary of operation
// - In user mode offer sector erase, byte program, byte read and hard lock.
// - No command sets read protection; it is only a tool programming option.
// - User program mode is refused while the CPU runs from the subsystem clock.
// - Any pending interrupt request aborts user program mode, even with interrupts disabled.
// - Masked requests abort too; only peripheral enables prevent the abort.
// - Writing A5h to the user mode key register enables user program mode.
// - Sector high and low registers select a 128-byte sector, e.g. 1000h-107Fh.
// - Writing A1h to the control register starts an erase; two dummy slots follow.
// - Writing zero to the key register disables user program mode.
// - Control bit 3 reads one after a failed sector erase.
// - Writing zero to the control register cancels the selected erase.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fupc_defs.vh"
module fupc_top #(
   parameter IRQ_W = 8
) (
   input  wire             clk,
   input  wire             nrst,
   input  wire [4:0]       avs_address,
   input  wire             avs_read,
   input  wire             avs_write,
   input  wire [31:0]      avs_writedata,
   input  wire [3:0]       avs_byteenable,
   output reg  [31:0]      avs_readdata,
   output wire             avs_waitrequest,
   input  wire [IRQ_W-1:0] irq_req,
   input  wire             cpu_on_subclk,
   output wire             fl_req,
   output reg  [1:0]       fl_cmd,
   output reg  [15:0]      fl_addr,
   output reg  [7:0]       fl_wdata,
   output reg              fl_abort,
   input  wire             fl_ack,
   input  wire             fl_fail,
   input  wire [7:0]       fl_rdata,
   output wire             mode_active
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_GUARD = 2'd1;
   localparam ST_RUN   = 2'd2;

   localparam integer GUARD_RAW = (`FUPC_GUARD_NS * `FUPC_CLK_MHZ + 999) / 1000;
   localparam integer GUARD_CYC = (GUARD_RAW < 1) ? 1 : GUARD_RAW;
   localparam [3:0]   GUARD_LD  = GUARD_CYC[3:0];

   reg        mode_q;
   reg [1:0]  state_q;
   reg [1:0]  state_d;
   reg [7:0]  sech_q;
   reg [7:0]  secl_q;
   reg [7:0]  adrh_q;
   reg [7:0]  adrl_q;
   reg [7:0]  data_q;
   reg        fail_q;
   reg        lock_q;
   reg        irq_abort_q;
   reg        sub_refused_q;
   reg [31:0] rd_mux;

   wire       accept;
   wire       capture;
   wire       guard_run;
   wire       guard_load;
   wire       wr_acc;
   wire [7:0] wb;
   wire       irq_any;
   wire       abort_cond;
   wire       busy;
   wire       wr_key;
   wire       wr_con;
   wire       idle_cmd;
   wire       cmd_erase;
   wire       cmd_prog;
   wire       cmd_read;
   wire       cmd_lock;
   wire       cmd_cancel;
   wire       cmd_start;

   fupc_avs_if u_bus (
      .clk         (clk),
      .nrst        (nrst),
      .read        (avs_read),
      .write       (avs_write),
      .stall       (guard_run),
      .waitrequest (avs_waitrequest),
      .accept      (accept),
      .capture     (capture)
   );

   fupc_cnt #(
      .W (4)
   ) u_guard (
      .clk     (clk),
      .nrst    (nrst),
      .load    (guard_load),
      .value   (GUARD_LD),
      .clear   (abort_cond),
      .running (guard_run)
   );

   assign wr_acc      = accept & avs_write & avs_byteenable[0];
   assign wb          = avs_writedata[7:0];
   assign irq_any     = |irq_req;
   assign abort_cond  = irq_any | cpu_on_subclk;
   assign busy        = (state_q != ST_IDLE);
   assign wr_key      = wr_acc & (avs_address == `FUPC_OFS_KEY);
   assign wr_con      = wr_acc & (avs_address == `FUPC_OFS_CON);
   assign idle_cmd    = wr_con & mode_q & ~busy & ~abort_cond;
   // Hard lock blocks every modifying command until reset
   assign cmd_erase   = idle_cmd & (wb == `FUPC_CMD_ERASE) & ~lock_q;
   assign cmd_prog    = idle_cmd & (wb == `FUPC_CMD_PROG) & ~lock_q;
   assign cmd_read    = idle_cmd & (wb == `FUPC_CMD_READ);
   assign cmd_lock    = idle_cmd & (wb == `FUPC_CMD_LOCK) & ~lock_q;
   // Any other code, read protection included, falls through unused
   assign cmd_start   = cmd_erase | cmd_prog | cmd_read | cmd_lock;
   assign cmd_cancel  = wr_con & (wb == `FUPC_CMD_CANCEL) & busy;
   assign guard_load  = cmd_erase;
   assign fl_req      = (state_q == ST_RUN);
   assign mode_active = mode_q;

   // User mode key
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= 1'b0;
      end else if (abort_cond) begin
         mode_q <= 1'b0;
      end else if (wr_key && wb == `FUPC_KEY_ENABLE) begin
         mode_q <= 1'b1;
      end else if (wr_key && wb == `FUPC_KEY_DISABLE) begin
         mode_q <= 1'b0;
      end
   end

   // Sticky causes of lost mode; a new key write clears, a new event wins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_abort_q   <= 1'b0;
         sub_refused_q <= 1'b0;
      end else begin
         if ((mode_q || busy) && irq_any) begin
            irq_abort_q <= 1'b1;
         end else if (wr_key) begin
            irq_abort_q <= 1'b0;
         end
         if (cpu_on_subclk && (mode_q || wr_key)) begin
            sub_refused_q <= 1'b1;
         end else if (wr_key) begin
            sub_refused_q <= 1'b0;
         end
      end
   end

   // Address and data registers; bus writes ignored while busy, data takes the read result
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sech_q <= `FUPC_RST_BYTE;
         secl_q <= `FUPC_RST_BYTE;
         adrh_q <= `FUPC_RST_BYTE;
         adrl_q <= `FUPC_RST_BYTE;
         data_q <= `FUPC_RST_BYTE;
      end else begin
         if (wr_acc && !busy) begin
            case (avs_address)
               `FUPC_OFS_SECH: sech_q <= wb;
               `FUPC_OFS_SECL: secl_q <= wb;
               `FUPC_OFS_ADRH: adrh_q <= wb;
               `FUPC_OFS_ADRL: adrl_q <= wb;
               `FUPC_OFS_DATA: data_q <= wb;
               default: ;
            endcase
         end
         if (state_q == ST_RUN && fl_ack && fl_cmd == `FUPC_FL_READ) begin
            data_q <= fl_rdata;
         end
      end
   end

   // Sequencer next state
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (cmd_erase) begin
               state_d = ST_GUARD;
            end else if (cmd_prog || cmd_read || cmd_lock) begin
               state_d = ST_RUN;
            end
         end
         ST_GUARD: begin
            if (abort_cond || cmd_cancel) begin
               state_d = ST_IDLE;
            end else if (!guard_run) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fl_ack) begin
               state_d = ST_IDLE;
            end else if (abort_cond || cmd_cancel) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Flash command, address and write data are latched at command start
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fl_cmd   <= `FUPC_FL_ERASE;
         fl_addr  <= 16'h0000;
         fl_wdata <= 8'h00;
      end else if (cmd_start) begin
         fl_wdata <= data_q;
         if (cmd_erase) begin
            fl_cmd  <= `FUPC_FL_ERASE;
            fl_addr <= {sech_q, secl_q[7], 7'h00};
         end else if (cmd_prog) begin
            fl_cmd  <= `FUPC_FL_PROG;
            fl_addr <= {adrh_q, adrl_q};
         end else if (cmd_read) begin
            fl_cmd  <= `FUPC_FL_READ;
            fl_addr <= {adrh_q, adrl_q};
         end else begin
            fl_cmd  <= `FUPC_FL_LOCK;
            fl_addr <= {adrh_q, adrl_q};
         end
      end
   end

   // Abort pulse tells the array to stop an operation already handed over
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fl_abort <= 1'b0;
      end else begin
         fl_abort <= (state_q == ST_RUN) & ~fl_ack & (abort_cond | cmd_cancel);
      end
   end

   // Erase failure flag; an erase cut short by an abort also counts as failed
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fail_q <= 1'b0;
      end else if (cmd_erase) begin
         fail_q <= 1'b0;
      end else if (busy && fl_cmd == `FUPC_FL_ERASE) begin
         if (state_q == ST_RUN && fl_ack) begin
            fail_q <= fl_fail;
         end else if (abort_cond) begin
            fail_q <= 1'b1;
         end
      end
   end

   // Hard lock protection holds until reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lock_q <= 1'b0;
      end else if (state_q == ST_RUN && fl_ack && fl_cmd == `FUPC_FL_LOCK && !fl_fail) begin
         lock_q <= 1'b1;
      end
   end

   // Read data path
   always @* begin
      rd_mux = 32'h00000000;
      case (avs_address)
         `FUPC_OFS_KEY:  rd_mux[0] = mode_q;
         `FUPC_OFS_CON: begin
            rd_mux[`FUPC_CON_BUSY_BIT] = busy;
            rd_mux[`FUPC_CON_LOCK_BIT] = lock_q;
            rd_mux[`FUPC_CON_FAIL_BIT] = fail_q;
         end
         `FUPC_OFS_SECH: rd_mux[7:0] = sech_q;
         `FUPC_OFS_SECL: rd_mux[7:0] = secl_q;
         `FUPC_OFS_ADRH: rd_mux[7:0] = adrh_q;
         `FUPC_OFS_ADRL: rd_mux[7:0] = adrl_q;
         `FUPC_OFS_DATA: rd_mux[7:0] = data_q;
         `FUPC_OFS_STAT: begin
            rd_mux[`FUPC_ST_MODE_BIT] = mode_q;
            rd_mux[`FUPC_ST_BUSY_BIT] = busy;
            rd_mux[`FUPC_ST_IRQ_BIT]  = irq_abort_q;
            rd_mux[`FUPC_ST_SUB_BIT]  = sub_refused_q;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h00000000;
      end else if (capture) begin
         avs_readdata <= rd_mux;
      end
   end
endmodule

// *** shared/fupc_defs.vh ***
// Register map, key codes, field positions and timing for the flash user program control block
`ifndef FUPC_DEFS_VH
`define FUPC_DEFS_VH

// Byte offsets on the register bus
`define FUPC_OFS_KEY      5'h00
`define FUPC_OFS_CON      5'h04
`define FUPC_OFS_SECH     5'h08
`define FUPC_OFS_SECL     5'h0C
`define FUPC_OFS_ADRH     5'h10
`define FUPC_OFS_ADRL     5'h14
`define FUPC_OFS_DATA     5'h18
`define FUPC_OFS_STAT     5'h1C

// Key and command codes
`define FUPC_KEY_ENABLE   8'hA5
`define FUPC_KEY_DISABLE  8'h00
`define FUPC_CMD_ERASE    8'hA1
`define FUPC_CMD_PROG     8'hA2
`define FUPC_CMD_READ     8'hA3
`define FUPC_CMD_LOCK     8'hA4
`define FUPC_CMD_CANCEL   8'h00

// Flash array command encodings
`define FUPC_FL_ERASE     2'h0
`define FUPC_FL_PROG      2'h1
`define FUPC_FL_READ      2'h2
`define FUPC_FL_LOCK      2'h3

// Control register fields
`define FUPC_CON_BUSY_BIT 0
`define FUPC_CON_LOCK_BIT 2
`define FUPC_CON_FAIL_BIT 3

// Status register fields
`define FUPC_ST_MODE_BIT  0
`define FUPC_ST_BUSY_BIT  1
`define FUPC_ST_IRQ_BIT   2
`define FUPC_ST_SUB_BIT   3

// Reset values
`define FUPC_RST_BYTE     8'h00

// Sector size is 128 bytes: low 7 address bits are forced to zero
`define FUPC_SECT_LSB     7

// Settling time after an erase start (two dummy instruction slots)
`define FUPC_GUARD_NS     10
`define FUPC_CLK_MHZ      200

`endif

// *** rtl/fupc_cnt.v ***
// Down counter that times the settling window after an erase start
`timescale 1ns/1ps
module fupc_cnt #(
   parameter W = 4
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire         load,
   input  wire [W-1:0] value,
   input  wire         clear,
   output wire         running
);
   reg [W-1:0] cnt_q;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= {W{1'b0}};
      end else if (clear) begin
         cnt_q <= {W{1'b0}};
      end else if (load) begin
         cnt_q <= value;
      end else if (cnt_q != {W{1'b0}}) begin
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign running = (cnt_q != {W{1'b0}});
endmodule

// *** rtl/fupc_avs_if.v ***
// Avalon-MM slave handshake: one wait cycle per access, extra wait while stalled
`timescale 1ns/1ps
module fupc_avs_if (
   input  wire clk,
   input  wire nrst,
   input  wire read,
   input  wire write,
   input  wire stall,
   output wire waitrequest,
   output wire accept,
   output wire capture
);
   reg phase_q;
   wire req;

   assign req         = read | write;
   assign accept      = req & phase_q & ~stall;
   assign waitrequest = req & ~accept;
   // Read data is sampled every waiting cycle so it is fresh at the accept edge
   assign capture     = read & ~accept;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= req & ~accept;
      end
   end
endmodule

// *** dv/fupc_asserts.sv ***
// Port checker for the flash user program control block
`timescale 1ns/1ps
module fupc_chk #(
   parameter IRQ_W = 8
) (
   input wire             clk,
   input wire             nrst,
   input wire [4:0]       avs_address,
   input wire             avs_write,
   input wire [31:0]      avs_writedata,
   input wire [3:0]       avs_byteenable,
   input wire             avs_waitrequest,
   input wire [IRQ_W-1:0] irq_req,
   input wire             cpu_on_subclk,
   input wire             fl_req,
   input wire [1:0]       fl_cmd,
   input wire [15:0]      fl_addr,
   input wire             fl_abort,
   input wire             fl_ack,
   input wire             mode_active
);
   wire       wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
   wire [7:0] wd    = avs_writedata[7:0];
   wire       quiet = ~|irq_req & ~cpu_on_subclk;
   wire       key_w = wr_ok & (avs_address == 5'h00);
   wire       con_w = wr_ok & (avs_address == 5'h04);
   wire       bad   = wd != 8'hA1 && wd != 8'hA2 && wd != 8'hA3 && wd != 8'hA4 && wd != 8'h00;
   reg        lock_q;
   // Hard lock blocks later erases, so the erase check must know about it
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         lock_q <= 1'b0;
      else if (fl_req && fl_ack && fl_cmd == 2'h3)
         lock_q <= 1'b1;
   end
   wire       erase_go = con_w && wd == 8'hA1 && mode_active && !fl_req && quiet && !lock_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_key_enable: assert property (key_w && wd == 8'hA5 && quiet |=> mode_active)
      else $error("enable key did not start mode");
   a_key_disable: assert property (key_w && wd == 8'h00 |=> !mode_active)
      else $error("zero key left mode on");
   a_subclk_stop: assert property (cpu_on_subclk |=> !fl_req)
      else $error("flash request while on subsystem clock");
   a_irq_abort: assert property (fl_req && irq_req != 0 |=> !fl_req && fl_abort)
      else $error("pending request did not abort");
   a_erase_start: assert property (erase_go |-> ##[1:4] (fl_req && fl_cmd == 2'h0))
      else $error("erase did not start");
   a_sector_align: assert property (fl_req && fl_cmd == 2'h0 |-> fl_addr[6:0] == 7'h00)
      else $error("erase address not sector aligned");
   a_cancel_op: assert property (con_w && wd == 8'h00 && fl_req |=> !fl_req && fl_abort)
      else $error("cancel did not stop operation");
   a_bad_code: assert property (con_w && bad && !fl_req |=> !fl_req [*4])
      else $error("undefined code started operation");
   a_mode_gate: assert property ($rose(fl_req) |-> $past(mode_active))
      else $error("operation started outside mode");
   c_erase_done: cover property (fl_req && fl_ack && fl_cmd == 2'h0);
   c_abort: cover property (fl_abort);
   c_lock_done: cover property (fl_req && fl_ack && fl_cmd == 2'h3);
endmodule
bind fupc_top fupc_chk #(.IRQ_W(IRQ_W)) u_chk (.clk, .nrst, .avs_address, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_waitrequest, .irq_req, .cpu_on_subclk, .fl_req, .fl_cmd, .fl_addr, .fl_abort,
   .fl_ack, .mode_active);

// *** dv/fupc_tb.sv ***
// Self-checking bench for the flash user program control block
`timescale 1ns/1ps
module testbench;
   reg         clk = 1'b0;
   reg         nrst = 1'b0;
   reg  [4:0]  avs_address = 5'h00;
   reg         avs_read = 1'b0;
   reg         avs_write = 1'b0;
   reg  [31:0] avs_writedata = 32'h0;
   reg  [3:0]  avs_byteenable = 4'hF;
   reg  [7:0]  irq_req = 8'h00;
   reg         cpu_on_subclk = 1'b0;
   reg         fl_ack = 1'b0;
   reg         fl_fail = 1'b0;
   reg  [7:0]  fl_rdata = 8'h5C;
   reg         ack_en = 1'b1;
   reg  [2:0]  ack_cnt = 3'h0;
   reg  [7:0]  rd;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest;
   wire        fl_req;
   wire        fl_abort;
   wire        mode_active;
   wire [1:0]  fl_cmd;
   wire [15:0] fl_addr;
   wire [7:0]  fl_wdata;
   integer     error_cnt = 0;
   integer     checks_done = 0;
   fupc_top #(.IRQ_W(8)) u_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_req, .cpu_on_subclk, .fl_req, .fl_cmd,
      .fl_addr, .fl_wdata, .fl_abort, .fl_ack, .fl_fail, .fl_rdata, .mode_active);
   initial forever #2.5 clk = ~clk;
   // Flash stand-in: acks on the fifth busy cycle, or never when held stuck
   always @(posedge clk) begin
      fl_ack <= 1'b0;
      ack_cnt <= fl_req ? ack_cnt + 3'h1 : 3'h0;
      if (fl_req && !fl_ack && ack_en && ack_cnt == 3'h3)
         fl_ack <= 1'b1;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      if (error_cnt == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task bus(input wr, input [4:0] a, input [7:0] d);
      integer n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk);
         n = n + 1;
      end
      if (avs_waitrequest !== 1'b0)
         error_cnt = error_cnt + 1;
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // Let this edge's register updates land before anyone samples
      @(negedge clk);
   endtask
   task wait_req(input exp);
      integer n;
      n = 0;
      while (fl_req !== exp && n < 20) begin
         @(negedge clk);
         n = n + 1;
      end
      // A request that never moves counts as a mismatch
      if (fl_req !== exp)
         error_cnt = error_cnt + 1;
   endtask
   task setf(input en, input fail);
      @(posedge clk);
      ack_en <= en;
      fl_fail <= fail;
   endtask
   task t_erase;
      bus(1, 5'h00, 8'hA5);
      chk(mode_active, 1);
      setf(1, 1);
      bus(1, 5'h08, 8'h10);
      bus(1, 5'h0C, 8'hFF);
      bus(1, 5'h04, 8'hA1);
      wait_req(1);
      chk({fl_req, fl_cmd, fl_addr}, {1'b1, 2'h0, 16'h1080});
      wait_req(0);
      bus(0, 5'h04, 8'h00);
      chk(rd & 8'h08, 8'h08);
   endtask
   task t_ops;
      setf(1, 0);
      bus(1, 5'h10, 8'h12);
      bus(1, 5'h14, 8'h34);
      bus(1, 5'h18, 8'h5A);
      bus(1, 5'h04, 8'hA2);
      wait_req(1);
      chk({fl_req, fl_cmd, fl_addr, fl_wdata}, {1'b1, 2'h1, 16'h1234, 8'h5A});
      wait_req(0);
      bus(1, 5'h04, 8'hA3);
      wait_req(1);
      chk(fl_cmd, 2'h2);
      wait_req(0);
      bus(0, 5'h18, 8'h00);
      chk(rd, 8'h5C);
   endtask
   task t_abort;
      setf(0, 0);
      bus(1, 5'h04, 8'hA1);
      wait_req(1);
      bus(1, 5'h04, 8'h00);
      chk({fl_req, fl_abort}, 2'h1);
      bus(1, 5'h04, 8'hA2);
      wait_req(1);
      // A masked source still counts as pending
      @(posedge clk);
      irq_req <= 8'h80;
      repeat (2) @(negedge clk);
      chk({fl_req, fl_abort}, 2'h1);
      bus(0, 5'h1C, 8'h00);
      chk(rd[2], 1);
      @(posedge clk);
      irq_req <= 8'h00;
   endtask
   task t_refuse;
      setf(1, 0);
      cpu_on_subclk <= 1'b1;
      bus(1, 5'h00, 8'hA5);
      chk(mode_active, 0);
      bus(1, 5'h04, 8'hA2);
      repeat (3) @(negedge clk);
      chk(fl_req, 0);
      @(posedge clk);
      cpu_on_subclk <= 1'b0;
      bus(1, 5'h00, 8'h00);
      bus(1, 5'h00, 8'h5A);
      chk(mode_active, 0);
      bus(1, 5'h04, 8'hA2);
      repeat (3) @(negedge clk);
      chk(fl_req, 0);
      bus(1, 5'h00, 8'hA5);
      bus(1, 5'h04, 8'h77);
      repeat (3) @(negedge clk);
      chk({mode_active, fl_req}, 2'h2);
      bus(1, 5'h00, 8'h00);
      chk(mode_active, 0);
   endtask
   task t_lock;
      bus(1, 5'h00, 8'hA5);
      bus(1, 5'h04, 8'hA4);
      wait_req(1);
      chk(fl_cmd, 2'h3);
      wait_req(0);
      bus(0, 5'h04, 8'h00);
      chk(rd & 8'h04, 8'h04);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_erase;
      t_ops;
      t_abort;
      t_refuse;
      t_lock;
      wrap_up;
   end
   initial begin
      #20000;
      error_cnt = error_cnt + 1;
      wrap_up;
   end
endmodule
